// [pkg/low_power_counter_consts.svh]
// register map, field positions and reset values of the slow counter
// How it works
// - in standby the counter runs only while standby_run (control bit 7) is set.
// - prescaler field bits 6:3 divides the slow clock by 2 to the code.
// - control and count writes take effect two slow-clock cycles later.
// - control bit 0 counter_enable runs the counter; zero holds it stopped.
// - status bits 3..0 show compare, period, count, control sync busy.
// - compare interrupt requested when irq_enable bit 1 and compare flag set.
// - wrap interrupt requested when irq_enable bit 0 and wrap flag set.
// - compare flag set on count equal to match_value; write one clears.
// - at top_value the count wraps to zero, setting wrap flag; write one clears.
// - one shared temporary byte, directly readable and writable, pairs bytes.
// - without debug_keep_running the counter halts during break debug.
// - source_select picks 32 kHz, 1 kHz, crystal or external slow clock.
// - count low byte at its offset, high byte at offset plus one.
`ifndef LOW_POWER_COUNTER_CONSTS_SVH
`define LOW_POWER_COUNTER_CONSTS_SVH

`define ADDR_W 5
`define OFS_COUNTER_CONTROL 5'h00
`define OFS_SYNC_BUSY_FLAGS 5'h01
`define OFS_IRQ_ENABLE 5'h02
`define OFS_IRQ_FLAGS 5'h03
`define OFS_WIDE_ACCESS_LATCH 5'h04
`define OFS_DEBUG_HALT_CONTROL 5'h05
`define OFS_SOURCE_SELECT 5'h07
`define OFS_COUNT_LO 5'h08
`define OFS_COUNT_HI 5'h09
`define OFS_TOP_LO 5'h0A
`define OFS_TOP_HI 5'h0B
`define OFS_MATCH_LO 5'h0C
`define OFS_MATCH_HI 5'h0D

`define BIT_STANDBY_RUN 7
`define BIT_COUNTER_ENABLE 0
`define PRESC_MSB 6
`define PRESC_LSB 3
`define BIT_MATCH 1
`define BIT_WRAP 0
`define BIT_DEBUG_KEEP_RUNNING 0
`define SYNC_CONTROL 0
`define SYNC_COUNT 1
`define SYNC_TOP 2
`define SYNC_MATCH 3

`define RST_CONTROL 8'h00
`define RST_COUNT 16'h0000
`define RST_TOP 16'hFFFF
`define RST_MATCH 16'h0000
`define SYNC_LATENCY 2'h2

`endif

// [pkg/low_power_counter_pkg.sv]
// types shared by the slow counter design
`default_nettype none
package low_power_counter_pkg;
  typedef enum logic [1:0] {
    src_ulp_32k,
    src_ulp_1k,
    src_crystal,
    src_ext_pin
  } source_type;
endpackage
`default_nettype wire

// [src/low_power_counter_regs.sv]
// slow real-time counter with byte register port and sync busy tracking
`include "low_power_counter_consts.svh"
`default_nettype none
module low_power_counter_regs (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic ultra_low_power_osc,
  input wire logic ultra_low_power_osc_1k,
  input wire logic crystal_osc,
  input wire logic ext_slow_clock_pin,
  input wire logic standby_sleep,
  input wire logic debug_break,
  output logic irq,
  output logic [1:0] source_out
);
  import low_power_counter_pkg::*;

  // overview of the block
  // - software talks to byte registers over a strobe port on ref_clk
  // - the slow clock is never used as a clock: its selected level is
  //   sampled on ref_clk and each rising edge becomes a one-cycle enable
  // - control, count, top and match writes land in a shadow first and
  //   reach the live copy only after two slow edges, as the real crossing
  //   would; the busy bits in the status register track that wait
  // - everything runs on one clock, so no real metastability exists here;
  //   the latency is kept so that software sees the documented timing
  // - standby and debug halts are plain levels and act at once
  // - interrupt flags are sticky; set wins over any clear in one cycle

  // ************************************************************
  // software-visible registers
  // ************************************************************
  logic [7:0] ctrl_shadow;
  logic [7:0] ctrl_live;
  logic [1:0] irq_enable;
  logic [1:0] irq_flags;
  logic [7:0] wide_access_latch;
  logic debug_keep_running;
  source_type source_select;
  logic [15:0] count_value;
  logic [15:0] count_shadow;
  logic [15:0] top_shadow;
  logic [15:0] top_value;
  logic [15:0] match_shadow;
  logic [15:0] match_value;
  logic [1:0] sync_pend [4];
  logic [3:0] sync_busy;
  logic [3:0] sync_start;
  logic [3:0] sync_done;

  // address decodes shared by several processes below; keeping them in
  // one place means a new offset only has to be added once
  logic wr_ctrl;
  logic wr_temp;
  logic rd_flags;
  logic wr_flags;

  assign wr_ctrl = wr_en && (addr == `OFS_COUNTER_CONTROL);
  assign wr_temp = wr_en && (addr == `OFS_WIDE_ACCESS_LATCH);
  assign rd_flags = rd_en && (addr == `OFS_IRQ_FLAGS);
  assign wr_flags = wr_en && (addr == `OFS_IRQ_FLAGS);

  // a high byte write commits the paired value and starts a crossing
  assign sync_start[`SYNC_CONTROL] = wr_ctrl;
  assign sync_start[`SYNC_COUNT] = wr_en && (addr == `OFS_COUNT_HI);
  assign sync_start[`SYNC_TOP] = wr_en && (addr == `OFS_TOP_HI);
  assign sync_start[`SYNC_MATCH] = wr_en && (addr == `OFS_MATCH_HI);

  // ************************************************************
  // slow clock source selection and edge detection
  // ************************************************************
  logic src_level;
  logic src_prev;
  logic src_edge;

  // the chosen level must already be running; no glitch-free switch here
  // switching source mid-count can give one spurious or one lost edge:
  // the previous level belongs to the old source, so the first sample of
  // the new one may look like a rise; software should stop the counter
  // before it changes the source if an exact count matters
  always_comb
  begin
    unique case (source_select)
      src_ulp_32k: src_level = ultra_low_power_osc;
      src_ulp_1k: src_level = ultra_low_power_osc_1k;
      src_crystal: src_level = crystal_osc;
      src_ext_pin: src_level = ext_slow_clock_pin;
    endcase
  end

  // pins are synchronous to ref_clk, so a single stage finds edges
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      src_prev <= 1'b0;
    else
      src_prev <= src_level;
  end

  assign src_edge = src_level && !src_prev;
  assign source_out = source_select;

  // ************************************************************
  // crossing into the slow domain: two slow edges of latency
  // ************************************************************
  // a new write restarts the wait; overlapping writes are the caller's risk
  // each tracker is a two-bit down counter: loaded on the committing
  // write, stepped by slow edges, and the step from one to zero is the
  // moment the shadow moves to the live copy
  // a write in the same cycle as that last step wins, so the newer value
  // is never overwritten by the one it replaced
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
        sync_pend[i] <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (sync_start[i])
          sync_pend[i] <= `SYNC_LATENCY;
        else if (src_edge && sync_pend[i] != 2'h0)
          sync_pend[i] <= sync_pend[i] - 2'h1;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      sync_busy[i] = (sync_pend[i] != 2'h0);
      sync_done[i] = src_edge && (sync_pend[i] == 2'h1) && !sync_start[i];
    end
  end

  // ************************************************************
  // control, enable and configuration registers
  // ************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_shadow <= `RST_CONTROL;
    else if (wr_ctrl)
      ctrl_shadow <= {wdata[7:3], 2'b00, wdata[0]};
  end

  // the live copy is what the slow logic obeys
  // readback shows the shadow, so software sees its own write at once
  // even while the live copy still runs on the older setting
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_live <= `RST_CONTROL;
    else if (sync_done[`SYNC_CONTROL])
      ctrl_live <= ctrl_shadow;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_enable <= 2'h0;
      debug_keep_running <= 1'b0;
      source_select <= src_ulp_32k;
    end
    else if (wr_en)
    begin
      if (addr == `OFS_IRQ_ENABLE)
        irq_enable <= wdata[1:0];
      if (addr == `OFS_DEBUG_HALT_CONTROL)
        debug_keep_running <= wdata[`BIT_DEBUG_KEEP_RUNNING];
      if (addr == `OFS_SOURCE_SELECT)
        source_select <= source_type'(wdata[1:0]);
    end
  end

  // ************************************************************
  // shared temporary byte and 16-bit staging
  // ************************************************************
  logic low_read;

  assign low_read = rd_en && (addr == `OFS_COUNT_LO || addr == `OFS_TOP_LO ||
                              addr == `OFS_MATCH_LO);

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wide_access_latch <= 8'h00;
    else if (wr_temp)
      wide_access_latch <= wdata;
    else if (wr_en && (addr == `OFS_COUNT_LO || addr == `OFS_TOP_LO ||
                       addr == `OFS_MATCH_LO))
      wide_access_latch <= wdata;
    else if (low_read)
    begin
      unique case (addr)
        `OFS_COUNT_LO: wide_access_latch <= count_value[15:8];
        `OFS_TOP_LO: wide_access_latch <= top_shadow[15:8];
        default: wide_access_latch <= match_shadow[15:8];
      endcase
    end
  end

  // the high byte joins the staged low byte in one write
  // a lone high write pairs with whatever the shared byte holds, which
  // may be a value left by a read or a direct write; software that mixes
  // accesses must write the low byte again first
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_shadow <= `RST_COUNT;
      top_shadow <= `RST_TOP;
      match_shadow <= `RST_MATCH;
    end
    else
    begin
      if (sync_start[`SYNC_COUNT])
        count_shadow <= {wdata, wide_access_latch};
      if (sync_start[`SYNC_TOP])
        top_shadow <= {wdata, wide_access_latch};
      if (sync_start[`SYNC_MATCH])
        match_shadow <= {wdata, wide_access_latch};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      top_value <= `RST_TOP;
      match_value <= `RST_MATCH;
    end
    else
    begin
      if (sync_done[`SYNC_TOP])
        top_value <= top_shadow;
      if (sync_done[`SYNC_MATCH])
        match_value <= match_shadow;
    end
  end

  // ************************************************************
  // prescaler and counter
  // ************************************************************
  logic [14:0] presc_cnt;
  logic [15:0] presc_mask_w;
  logic [14:0] presc_mask;
  logic run_ok;
  logic tick;
  logic at_top;
  logic [15:0] next_count;

  // standby and debug halts freeze the prescaler too, so no tick is lost
  // the prescaler is a free binary counter; a tick falls on every edge at
  // which its low k bits are all ones, which divides by two to the k
  // without a separate reload value
  // disabling clears it, so every enable starts a fresh division period
  assign run_ok = ctrl_live[`BIT_COUNTER_ENABLE]
    && (!standby_sleep || ctrl_live[`BIT_STANDBY_RUN])
    && (!debug_break || debug_keep_running);

  assign presc_mask_w = (16'h0001 << ctrl_live[`PRESC_MSB:`PRESC_LSB]) -
                        16'h0001;
  assign presc_mask = presc_mask_w[14:0];
  assign tick = src_edge && run_ok &&
                ((presc_cnt & presc_mask) == presc_mask);

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      presc_cnt <= 15'h0000;
    else if (!ctrl_live[`BIT_COUNTER_ENABLE])
      presc_cnt <= 15'h0000;
    else if (src_edge && run_ok)
      presc_cnt <= presc_cnt + 15'h0001;
  end

  assign at_top = (count_value == top_value);
  assign next_count = at_top ? 16'h0000 : count_value + 16'h0001;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      count_value <= `RST_COUNT;
    else if (sync_done[`SYNC_COUNT])
      count_value <= count_shadow;
    else if (tick)
      count_value <= next_count;
  end

  // ************************************************************
  // interrupt flags: set wins over read or write-one clear
  // ************************************************************
  logic [1:0] flag_set;
  logic [1:0] flag_clr;

  assign flag_set[`BIT_WRAP] = tick && at_top;
  assign flag_set[`BIT_MATCH] = tick && (next_count == match_value);
  assign flag_clr = rd_flags ? 2'b11 : (wr_flags ? wdata[1:0] : 2'b00);

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_flags <= 2'h0;
    else
      irq_flags <= (irq_flags & ~flag_clr) | flag_set;
  end

  // level request, held until software clears the flag
  // the request is not registered: a mask write takes effect in the very
  // cycle after it, which keeps masking immediate for the interrupt
  // controller at the cost of a combinational path from two registers
  assign irq = |(irq_flags & irq_enable);

  // ************************************************************
  // read port: data stands in the cycle after the strobe
  // ************************************************************
  // the read mux is combinational and the result is registered once;
  // rdata returns to zero after its cycle so a stale value is never
  // mistaken for a fresh answer
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (addr)
      `OFS_COUNTER_CONTROL: next_rdata = ctrl_shadow;
      `OFS_SYNC_BUSY_FLAGS: next_rdata = {4'h0, sync_busy};
      `OFS_IRQ_ENABLE: next_rdata = {6'h00, irq_enable};
      `OFS_IRQ_FLAGS: next_rdata = {6'h00, irq_flags};
      `OFS_WIDE_ACCESS_LATCH: next_rdata = wide_access_latch;
      `OFS_DEBUG_HALT_CONTROL: next_rdata = {7'h00, debug_keep_running};
      `OFS_SOURCE_SELECT: next_rdata = {6'h00, source_select};
      `OFS_COUNT_LO: next_rdata = count_value[7:0];
      `OFS_TOP_LO: next_rdata = top_shadow[7:0];
      `OFS_MATCH_LO: next_rdata = match_shadow[7:0];
      `OFS_COUNT_HI, `OFS_TOP_HI, `OFS_MATCH_HI:
        next_rdata = wide_access_latch;
      default: next_rdata = 8'h00; // unmapped reads zero
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (rd_en)
      rdata <= next_rdata;
    else
      rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// [bench/low_power_counter_chk.sv]
// port checker of the slow counter register block
`default_nettype none
module low_power_counter_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic [1:0] source_out
);
  // ******************************
  // register port relations
  // ******************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // source select output follows only its own register
  a_source_load: assert property (
    wr_en && addr == 5'h07 |=> source_out == $past(wdata[1:0]))
    else $error("source select not loaded");
  a_source_hold: assert property (
    !(wr_en && addr == 5'h07) |=> $stable(source_out))
    else $error("source select changed without write");
  // a direct write to the shared byte reads back unchanged
  a_temp_back: assert property (
    wr_en && addr == 5'h04 ##1 !wr_en ##1 rd_en && addr == 5'h04
    |=> rdata == $past(wdata, 3)) else $error("shared byte lost");
  a_ctrl_back: assert property (
    wr_en && addr == 5'h00 ##1 !wr_en ##1 rd_en && addr == 5'h00
    |=> rdata == ($past(wdata, 3) & 8'hF9))
    else $error("control readback wrong");
  // control busy is up right after a write; needs two slow edges to drop
  a_busy_set: assert property (
    wr_en && addr == 5'h00 ##2 rd_en && addr == 5'h01 |=> rdata[0])
    else $error("control busy not raised");
  a_status_top: assert property (
    rd_en && addr == 5'h01 |=> rdata[7:4] == 4'h0)
    else $error("status upper bits set");
  a_flags_top: assert property (
    rd_en && addr == 5'h03 |=> rdata[7:2] == 6'h00)
    else $error("flag upper bits set");
  a_irq_masked: assert property (
    wr_en && addr == 5'h02 && wdata[1:0] == 2'b00 |=> !irq)
    else $error("interrupt seen while masked");
endmodule
bind low_power_counter_regs low_power_counter_chk u_low_power_counter_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
  .source_out(source_out));
`default_nettype wire

// [bench/low_power_counter_regs_test.sv]
// self-checking bench of the slow counter registers
`default_nettype none
module low_power_counter_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic slow = 1'b0;
  logic standby_sleep = 1'b0;
  logic debug_break = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [1:0] source_out;
  logic [7:0] d;
  logic [7:0] lo;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] rst_val [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
  // ******************************
  // clock, hang limit, device
  // ******************************
  always #2 ref_clk = ~ref_clk;
  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_mismatch++;
      results();
    end
  end
  low_power_counter_regs u_low_power_counter_regs (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ultra_low_power_osc(slow),
    .ultra_low_power_osc_1k(slow), .crystal_osc(slow),
    .ext_slow_clock_pin(slow), .standby_sleep(standby_sleep),
    .debug_break(debug_break), .irq(irq), .source_out(source_out));
  // ******************************
  // shared tasks
  // ******************************
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  // low byte read snaps the high byte, which then comes from the pair
  task automatic rdc(input logic [15:0] exp);
    rd(5'h08);
    lo = d;
    rd(5'h09);
    chk("count", {d, lo}, exp);
  endtask
  // slow edges are eight fast cycles apart, so edge detection settles
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      slow <= 1'b1;
      repeat (4) @(posedge ref_clk);
      slow <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task automatic results();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset();
    for (int a = 0; a < 14; a++)
    begin
      rd(a[4:0]);
      chk("reset value", d, rst_val[a]);
    end
    wr(5'h06, 8'hFF);
    rd(5'h06);
    chk("unmapped", d, 8'h00);
    wr(5'h04, 8'h5A);
    rd(5'h04);
    chk("shared byte", d, 8'h5A);
  endtask
  task automatic t_source();
    // every source input carries the same running slow level, so the
    // crystal and the pin count as prepared before they are chosen
    for (int i = 0; i < 4; i++)
    begin
      wr(5'h07, i[7:0]);
      chk("source out", source_out, i[1:0]);
    end
    wr(5'h07, 8'h00);
  endtask
  task automatic t_count();
    rd(5'h01);
    chk("idle before pair writes", d, 8'h00);
    wr(5'h0A, 8'h04);
    wr(5'h0B, 8'h01);
    wr(5'h0C, 8'h03);
    wr(5'h0D, 8'h01);
    wr(5'h08, 8'h02);
    wr(5'h09, 8'h01);
    rd(5'h01);
    chk("busy", d, 8'h0E);
    edges(2);
    rd(5'h01);
    chk("busy done", d, 8'h00);
    rdc(16'h0102);
    rd(5'h04);
    chk("shared byte", d, 8'h01);
  endtask
  task automatic t_run();
    standby_sleep <= 1'b1;
    wr(5'h02, 8'h03);
    wr(5'h00, 8'h01);
    rd(5'h01);
    chk("control busy", d, 8'h01);
    edges(3);
    rdc(16'h0102);
    standby_sleep <= 1'b0;
    debug_break <= 1'b1;
    edges(2);
    rdc(16'h0102);
    debug_break <= 1'b0;
    edges(1);
    chk("match irq", irq, 1'b1);
    rd(5'h03);
    chk("match flag", d, 8'h02);
    chk("irq cleared", irq, 1'b0);
    rdc(16'h0103);
    edges(2);
    chk("wrap irq", irq, 1'b1);
    rdc(16'h0000);
    wr(5'h02, 8'h00);
    chk("masked irq", irq, 1'b0);
    wr(5'h03, 8'h01);
    rd(5'h03);
    chk("wrap flag", d, 8'h00);
  endtask
  task automatic t_presc();
    rd(5'h01);
    chk("control idle", d, 8'h00);
    debug_break <= 1'b1;
    wr(5'h00, 8'h89);
    rd(5'h00);
    chk("control", d, 8'h89);
    standby_sleep <= 1'b1;
    edges(3);
    rdc(16'h0000);
    debug_break <= 1'b0;
    edges(4);
    rdc(16'h0002);
    wr(5'h05, 8'h01);
    debug_break <= 1'b1;
    edges(2);
    rdc(16'h0003);
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_source();
    t_count();
    t_run();
    t_presc();
    results();
  end
endmodule
`default_nettype wire
